// File: dfr_fault_response.sv
/*
 satellite fault response: undervoltage supervision, memory parity, bus switch,
 read answers. assumes commands arrive decoded and are held valid until cmd_ready, and that
 samples and hold-cap comparator level are synchronous to clk.
*/
`timescale 1ns/100ps
module dfr_fault_response #(
   parameter int UV_LIMIT = dfr_pkg::UV_LIMIT_CYC
) (
   input  wire logic                            clk,
   input  wire logic                            rstn,
   input  wire logic                            hold_cap_supply_low,
   input  wire logic [dfr_pkg::SAMPLE_W-1:0]    sample,
   input  wire dfr_pkg::dfr_cmd_s               cmd,
   input  wire logic                            cmd_valid,
   input  wire logic [dfr_pkg::CUST_BITS-1:0]   cust_wr_data,
   input  wire logic                            cust_wr_bus,
   input  wire logic                            cust_wr_trim,
   input  wire logic [dfr_pkg::OTP_BITS-1:0]    otp_load,
   input  wire logic                            resp_ready,
   output dfr_pkg::dfr_resp_s                   resp,
   output logic                                 resp_valid,
   output logic                                 cmd_ready,
   output logic                                 switch_closed,
   output logic                                 master_on_downstream,
   output logic                                 uv_flag,
   output logic                                 parity_fault,
   output logic                                 por_active
);
   if (UV_LIMIT < 1)
   begin : g_bad_limit
      $error("UV_LIMIT must be at least 1");
   end
   localparam int CW = $clog2(UV_LIMIT + 1);
   dfr_pkg::dfr_state_e       state;
   logic [CW-1:0]             uv_cnt;
   logic [7:0]                init_cnt;
   logic [dfr_pkg::OTP_BITS-1:0] otp;
   logic                      fac_par;
   logic                      cust_par;
   logic                      par_err;
   logic                      uv_long;
   dfr_pkg::dfr_resp_s        next_resp;
   logic                      fifo_ready;

   assign uv_long = hold_cap_supply_low && (uv_cnt >= CW'(UV_LIMIT));

   // undervoltage duration count
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) uv_cnt <= '0;
      else if (!hold_cap_supply_low) uv_cnt <= '0;
      else if (!uv_long) uv_cnt <= uv_cnt + 1'b1;
   end

   // power-on/post-reset sequence
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) begin
         state    <= dfr_pkg::DFR_RESET;
         init_cnt <= '0;
      end else begin
         case (state)
            dfr_pkg::DFR_RESET:
            begin
               init_cnt <= '0;
               if (!hold_cap_supply_low) state <= dfr_pkg::DFR_INIT;
            end
            dfr_pkg::DFR_INIT:
            begin
               init_cnt <= init_cnt + 8'h01;
               if (hold_cap_supply_low) state <= dfr_pkg::DFR_RESET;
               else if (init_cnt == 8'(dfr_pkg::INIT_CYC - 1)) state <= dfr_pkg::DFR_ACTIVE;
            end
            dfr_pkg::DFR_ACTIVE:
            begin
               if (uv_long) state <= dfr_pkg::DFR_RESET; // RULE_03
            end
            default: state <= dfr_pkg::DFR_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) por_active <= 1'b1;
      else por_active <= (state != dfr_pkg::DFR_ACTIVE) || uv_long; // RULE_03
   end

   // otp image; bit CUST_BASE-1 factory parity, bit OTP_BITS-1 customer parity
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) otp <= '0;
      else if (state == dfr_pkg::DFR_INIT && init_cnt == 8'h00) otp <= otp_load; // RULE_04
      else if (state == dfr_pkg::DFR_ACTIVE && (cust_wr_bus || cust_wr_trim))
         otp[dfr_pkg::CUST_BASE +: dfr_pkg::CUST_BITS] <=
            otp[dfr_pkg::CUST_BASE +: dfr_pkg::CUST_BITS] | cust_wr_data; // RULE_05
   end

   // even parity over each region including its parity bit
   assign fac_par  = ^otp[dfr_pkg::CUST_BASE-1:0]; // RULE_06
   assign cust_par = ^otp[dfr_pkg::OTP_BITS-1:dfr_pkg::CUST_BASE]; // RULE_06
   assign par_err  = fac_par || cust_par;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) parity_fault <= 1'b0;
      else parity_fault <= (state == dfr_pkg::DFR_ACTIVE) && par_err; // RULE_06
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) uv_flag <= 1'b0;
      else uv_flag <= hold_cap_supply_low && !uv_long; // RULE_02 RULE_12 RULE_13
   end

   // pass-through switch and port direction
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) begin
         switch_closed        <= 1'b0; // RULE_08
         master_on_downstream <= 1'b0;
      end else if (state != dfr_pkg::DFR_ACTIVE) begin
         switch_closed        <= 1'b0; // RULE_08
         master_on_downstream <= 1'b0;
      end else if (cmd_valid && cmd_ready &&
                   (cmd.op == dfr_pkg::CMD_INIT || cmd.op == dfr_pkg::CMD_REV_INIT)) begin
         switch_closed        <= cmd.data[dfr_pkg::SWITCH_BIT]; // RULE_09
         master_on_downstream <= (cmd.op == dfr_pkg::CMD_REV_INIT) && cmd.from_down; // RULE_10
      end
   end

   assign cmd_ready = fifo_ready && (state == dfr_pkg::DFR_ACTIVE) && !uv_long; // RULE_03

   always_comb
   begin
      next_resp.value        = sample; // RULE_11
      if (hold_cap_supply_low) next_resp.value = '0; // RULE_01 RULE_12
      if (par_err) next_resp.value = '0; // RULE_07
      next_resp.uv_flag      = hold_cap_supply_low; // RULE_02
      next_resp.parity_fault = par_err;
      next_resp.on_down      = cmd.from_down; // RULE_10
   end

   dfr_fifo #(
      .WIDTH ($bits(dfr_pkg::dfr_resp_s)),
      .DEPTH (4)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_data   (next_resp),
      .in_valid  (cmd_valid && cmd_ready && cmd.op == dfr_pkg::CMD_READ_SHORT),
      .in_ready  (fifo_ready),
      .out_data  (resp),
      .out_valid (resp_valid),
      .out_ready (resp_ready)
   );
endmodule // dfr_fault_response

// File: dfr_fault_response_assertions.sv
/* assertions on the fault-response ports.
 bound to every block instance; UV_LIMIT follows the block's own. */
`timescale 1ns/100ps
module dfr_checker #(
   parameter int UV_LIMIT = 20
) (
   input wire logic               clk,
   input wire logic               rstn,
   input wire logic               hold_cap_supply_low,
   input wire logic [9:0]         sample,
   input wire dfr_pkg::dfr_cmd_s  cmd,
   input wire logic               cmd_valid,
   input wire logic               cmd_ready,
   input wire dfr_pkg::dfr_resp_s resp,
   input wire logic               resp_valid,
   input wire logic               switch_closed,
   input wire logic               master_on_downstream,
   input wire logic               uv_flag,
   input wire logic               parity_fault,
   input wire logic               por_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire tk = cmd_valid && cmd_ready;
   wire rd = tk && cmd.op == dfr_pkg::CMD_READ_SHORT && !resp_valid;
   int  lc;
   // consecutive undervoltage cycles
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         lc <= 0;
      else
         lc <= hold_cap_supply_low ? lc + 1 : 0;
   property p_uv0; rd && hold_cap_supply_low |=> resp_valid && resp.value == 0; endproperty
   property p_uvf; $rose(hold_cap_supply_low) && cmd_ready |-> ##[1:2] uv_flag; endproperty
   property p_por; lc > UV_LIMIT + 2 |-> por_active && !cmd_ready && !switch_closed; endproperty
   property p_par0; rd && parity_fault |=> resp_valid && resp.value == 0; endproperty
   property p_swo; $rose(rstn) |-> !switch_closed; endproperty
   property p_swc; tk && cmd.op[1] && cmd.data[6] |=> switch_closed; endproperty
   property p_rev; tk && cmd.op == 2'h3 && cmd.from_down |=> master_on_downstream; endproperty
   property p_smp; rd && !hold_cap_supply_low && !parity_fault |=> resp.value == $past(sample);
   endproperty
   property p_short; hold_cap_supply_low && lc < UV_LIMIT - 4 && !por_active |=> !por_active;
   endproperty
   a_uv0: assert property (p_uv0) else $error("uv read not zero");
   a_uvf: assert property (p_uvf) else $error("uv flag missing");
   a_por: assert property (p_por) else $error("long uv not silent");
   a_par0: assert property (p_par0) else $error("parity read not zero");
   a_swo: assert property (p_swo) else $error("switch closed after reset");
   a_swc: assert property (p_swc) else $error("switch not closed");
   a_rev: assert property (p_rev) else $error("downstream master missing");
   a_smp: assert property (p_smp) else $error("read value wrong");
   a_short: assert property (p_short) else $error("short uv reset");
   c_uv: cover property (rd && hold_cap_supply_low);
   c_por: cover property (por_active && hold_cap_supply_low);
   c_full: cover property (resp_valid && !cmd_ready && !por_active);
endmodule // dfr_checker
bind dfr_fault_response dfr_checker #(.UV_LIMIT(UV_LIMIT)) u_chk (
   .clk                  (clk),
   .rstn                 (rstn),
   .hold_cap_supply_low  (hold_cap_supply_low),
   .sample               (sample),
   .cmd                  (cmd),
   .cmd_valid            (cmd_valid),
   .cmd_ready            (cmd_ready),
   .resp                 (resp),
   .resp_valid           (resp_valid),
   .switch_closed        (switch_closed),
   .master_on_downstream (master_on_downstream),
   .uv_flag              (uv_flag),
   .parity_fault         (parity_fault),
   .por_active           (por_active)
);

// File: dfr_fifo.sv
/*
 small flip-flop fifo with valid/ready on both sides.
 assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module dfr_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   // pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("depth must be power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end
   always_ff @(posedge clk)
   begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule // dfr_fifo

// File: dfr_master.sv
/* bus master model: issues decoded commands, takes answers.
 assumes tasks are called from the clk domain; answers stall until taken. */
`timescale 1ns/100ps
module dfr_master (
   input  wire logic               clk,
   input  wire logic               cmd_ready,
   input  wire dfr_pkg::dfr_resp_s resp,
   input  wire logic               resp_valid,
   output dfr_pkg::dfr_cmd_s       cmd = '0,
   output logic                    cmd_valid = 1'b0,
   output logic                    resp_ready = 1'b0
);
   // master sets the close bit itself when it wants the far segment
   task automatic send(input logic [1:0] op, input logic [7:0] d, input logic dn);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd       <= '{op, d, dn};
      do @(negedge clk); while (!cmd_ready);
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd       <= ~cmd;
   endtask
   task automatic take(output dfr_pkg::dfr_resp_s r);
      @(posedge clk);
      resp_ready <= 1'b1;
      do @(negedge clk); while (!resp_valid);
      r = resp;
      @(posedge clk);
      resp_ready <= 1'b0;
   endtask
endmodule // dfr_master

// File: dfr_pkg.sv
/*
 package of the satellite fault-response block: constants, states, carrier types.
 assumes a 100 MHz clock; bus framing and decoding happen outside this block.
*/
// Behaviour
// RULE_01: hold-cap low forces short read zero
// RULE_02: hold-cap low sets undervoltage flag
// RULE_03: undervoltage over 1 ms forces silent reset
// RULE_04: 128 memory bits, 80 customer bits
// RULE_05: customer bits writable from bus or trim
// RULE_06: continuous separate parity, factory and customer
// RULE_07: parity fault makes reads answer zero
// RULE_08: pass-through switch open after every reset
// RULE_09: init with switch_close_bit closes switch
// RULE_10: downstream pin may act as master port
// RULE_11: sample is 10 bits, sent 8 to 10
// RULE_12: short undervoltage keeps running, reports zero
// RULE_13: recovered supply restores real readings
package dfr_pkg;
   localparam int OTP_BITS       = 128;
   localparam int CUST_BITS      = 80;
   localparam int CUST_BASE      = 48;
   localparam int SAMPLE_W       = 10;
   localparam int SWITCH_BIT     = 6;
   localparam int UV_LIMIT_NS    = 1000000;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int UV_LIMIT_CYC   = UV_LIMIT_NS / CLK_PERIOD_NS;
   localparam int INIT_CYC       = 16;
   localparam logic [1:0] CMD_READ_SHORT = 2'h1;
   localparam logic [1:0] CMD_INIT       = 2'h2;
   localparam logic [1:0] CMD_REV_INIT   = 2'h3;

   typedef enum logic [1:0] {
      DFR_RESET  = 2'b00,
      DFR_INIT   = 2'b01,
      DFR_ACTIVE = 2'b10
   } dfr_state_e;

   typedef struct packed {
      logic [1:0] op;
      logic [7:0] data;
      logic       from_down;
   } dfr_cmd_s;

   typedef struct packed {
      logic [SAMPLE_W-1:0] value;
      logic                uv_flag;
      logic                parity_fault;
      logic                on_down;
   } dfr_resp_s;
endpackage

// File: test_dfr_fault_response.sv
/* self-checking bench of the fault-response block.
 assumes the package, fifo, master model and checker are compiled first. */
`timescale 1ns/100ps
module test_dfr_fault_response;
   logic               clk = 0, rstn = 0, hold_cap_supply_low = 0;
   logic               cust_wr_bus = 0, cust_wr_trim = 0;
   logic [9:0]         sample = '0;
   logic [79:0]        cust_wr_data = '0;
   logic [127:0]       otp_load = '0;
   logic               cmd_valid, resp_ready, resp_valid, cmd_ready, switch_closed;
   logic               master_on_downstream, uv_flag, parity_fault, por_active;
   dfr_pkg::dfr_cmd_s  cmd;
   dfr_pkg::dfr_resp_s resp, r;
   int                 n_fail = 0, cmp_count = 0, cyc = 0;
   always #5 clk = ~clk;
   dfr_fault_response #(.UV_LIMIT(20)) DUT (.*);
   dfr_master m (.*);
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic rst(input logic [127:0] img);
      @(posedge clk);
      otp_load <= img;
      rstn     <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      do @(negedge clk); while (!cmd_ready);
   endtask
   task automatic rd(input logic [9:0] v, input logic [9:0] e, input string n);
      @(posedge clk);
      sample <= v;
      m.send(dfr_pkg::CMD_READ_SHORT, 8'h00, 1'b0);
      m.take(r);
      chk(n, e, r.value);
   endtask
   task automatic s_uv;
      @(posedge clk);
      hold_cap_supply_low <= 1'b1;
      rd(10'h2a5, 10'h000, "uv value");
      @(negedge clk);
      chk("uv flag", 1, r.uv_flag);
      chk("uv pin", 1, uv_flag);
      chk("short por", 0, por_active);
      @(posedge clk);
      hold_cap_supply_low <= 1'b0;
      rd(10'h15a, 10'h15a, "recovered");
   endtask
   task automatic s_switch;
      m.send(dfr_pkg::CMD_INIT, 8'h40, 1'b0);
      @(negedge clk);
      chk("closed", 1, switch_closed);
      m.send(dfr_pkg::CMD_REV_INIT, 8'h40, 1'b1);
      @(negedge clk);
      chk("down master", 1, master_on_downstream);
   endtask
   task automatic s_long;
      @(posedge clk);
      hold_cap_supply_low <= 1'b1;
      repeat (30) @(negedge clk);
      chk("por", 1, por_active);
      chk("silent", 0, cmd_ready);
      chk("open", 0, switch_closed);
      @(posedge clk);
      hold_cap_supply_low <= 1'b0;
      do @(negedge clk); while (!cmd_ready);
      chk("open after", 0, switch_closed);
   endtask
   task automatic s_fill;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         sample <= 10'h100 + 10'(i);
         m.send(dfr_pkg::CMD_READ_SHORT, 8'h00, 1'b0);
      end
      @(negedge clk);
      chk("full", 0, cmd_ready);
      for (int i = 0; i < 4; i++)
      begin
         m.take(r);
         chk("drain", 16'h100 + 16'(i), r.value);
      end
      @(negedge clk);
      chk("empty", 0, resp_valid);
   endtask
   task automatic s_par;
      for (int k = 0; k < 3; k++)
      begin
         m.send(dfr_pkg::CMD_INIT, 8'h40, 1'b0);
         rst({127'h0, k == 2});
         chk("reset open", 0, switch_closed);
         chk("reset up master", 0, master_on_downstream);
         @(negedge clk);
         chk("clean", k == 2, parity_fault);
         @(posedge clk);
         cust_wr_data <= 80'(k < 2);
         cust_wr_bus  <= k == 0;
         cust_wr_trim <= k == 1;
         @(posedge clk);
         cust_wr_bus  <= 1'b0;
         cust_wr_trim <= 1'b0;
         repeat (3) @(negedge clk);
         chk("fault", 1, parity_fault);
         rd(10'h3ff, 10'h000, "fault value");
         chk("resp fault", 1, r.parity_fault);
      end
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      do @(negedge clk); while (!cmd_ready);
      rd(10'h2a5, 10'h2a5, "read");
      s_uv;
      s_switch;
      s_long;
      s_fill;
      s_par;
      end_of_test;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         end_of_test;
      end
   end
endmodule // test_dfr_fault_response
